//--- logic/agc_i2c_pkg.sv
// Shared constants for the serial control port and gain path
package agc_i2c_pkg;
  // Clock and glitch filter timing
  localparam int CLK_PERIOD_PS = 4000;   // 250 MHz core clock
  localparam int GLITCH_NS     = 50;     // Shortest pulse passed
  localparam int GLITCH_CYC    =
    (GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] GLITCH_CNT = 4'(GLITCH_CYC - 1);
  // Serial port addressing
  localparam logic [6:0] SLAVE_BASE = 7'h2a;  // Arbitrary value
  localparam logic [7:0] SUB_LAST   = 8'h17;  // Highest subaddress
  localparam int         REG_COUNT  = 24;
  // Register offsets
  localparam logic [7:0] REG_GAIN_LO = 8'h04;
  localparam logic [7:0] REG_GAIN_HI = 8'h05;
  localparam logic [7:0] REG_CLAMP0  = 8'h06;
  localparam logic [7:0] REG_CLAMP1  = 8'h07;
  localparam logic [7:0] REG_AUX0    = 8'h10;
  localparam int         AUX_COUNT   = 8;
  // Field positions and reset values
  localparam int         SYNC_GATE_BIT = 4;
  localparam int         GAIN_FRAC     = 9;
  localparam logic [7:0] GAIN_LO_RST   = 8'h00;
  localparam logic [7:0] GAIN_HI_RST   = 8'h04;
  localparam logic [11:0] GAIN_RST     = 12'h400;  // Gain of 2
  // Controller register map (byte offsets on the bus)
  localparam logic [3:0] WB_CMD  = 4'h0;
  localparam logic [3:0] WB_STAT = 4'h4;
  localparam int         CMD_RW  = 16;
  localparam int         CMD_A1  = 17;
  localparam int         QUARTER_CYC = 32;  // Quarter of a bit time
  // Controller transfer steps
  typedef enum logic [2:0] {
    OP_START, OP_TXB, OP_RXB, OP_STOP, OP_DONE
  } op_e;
endpackage

//--- logic/i2c_link_if.sv
// Two-wire link between the controller end and the device end
`timescale 1ns/10ps
`default_nettype none
interface i2c_link_if;
  logic scl_host_o;   // Clock level when driven
  logic scl_host_oe;  // Controller drives clock
  logic sda_host_o;   // Data level when driven
  logic sda_host_oe;  // Controller drives data
  logic sda_dev_o;    // Device data level when driven
  logic sda_dev_oe;   // Device drives data
  wire  scl;          // Resolved clock, pulled up
  wire  sda;          // Resolved data, pulled up

  // Open-drain wired AND with pull-ups
  assign scl = scl_host_oe ? scl_host_o : 1'b1;
  assign sda = (sda_host_oe ? sda_host_o : 1'b1) &
               (sda_dev_oe ? sda_dev_o : 1'b1);

  modport dev  (input scl, sda, output sda_dev_o, sda_dev_oe);
  modport host (input scl, sda,
                output scl_host_o, scl_host_oe, sda_host_o, sda_host_oe);
endinterface
`default_nettype wire

//--- logic/i2c_master_end.sv
// Bus controller end: Wishbone commands turned into link transfers
`timescale 1ns/10ps
`default_nettype none
module i2c_master_end #(
  parameter int QUARTER = agc_i2c_pkg::QUARTER_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  i2c_link_if.host         link,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);
  import agc_i2c_pkg::*;

  logic [23:0] cmd;       // Data, subaddress, direction, address bit
  logic        busy;      // Transfer running
  logic        nack;      // Device refused a byte
  logic [7:0]  rx;        // Byte read back
  logic [2:0]  step;      // Position in the transfer
  logic [1:0]  q;         // Quarter within a bit
  logic [3:0]  bitn;      // Bit within a byte
  logic [15:0] div;       // Quarter divider
  logic        sda_s1;    // Data synchroniser
  logic        sda_s2;
  logic        scl_oe;
  logic        sda_oe;
  op_e         op;
  logic [7:0]  txb;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire acc   = wb_cyc_i & wb_stb_i;
  wire wr    = acc & wb_we_i & wb_ack_o;
  wire go    = wr & (wb_adr_i == WB_CMD) & wb_sel_i[0] & ~busy;
  wire tick  = busy & (div == 16'(QUARTER - 1));
  wire rw    = cmd[CMD_RW];
  wire [7:0] adr_w = {SLAVE_BASE[6:1], cmd[CMD_A1], 1'b0};
  wire [2:0] stop_step = rw ? 3'h6 : 3'h4;
  wire [31:0] rd_mux = (wb_adr_i == WB_CMD)  ? {8'h00, cmd} :
                       (wb_adr_i == WB_STAT) ? {16'h0, rx, 6'h0, nack, busy}
                                             : 32'h0;

  // Transfer script: write is start, address, sub, data, stop;
  // read swaps the data byte for a repeated start, read address and one byte
  always_comb begin
    op  = OP_DONE;
    txb = 8'h00;
    unique case (step)
      3'h0: op = OP_START;
      3'h1: begin
        op  = OP_TXB;
        txb = adr_w;
      end
      3'h2: begin
        op  = OP_TXB;
        txb = cmd[15:8];
      end
      3'h3: begin
        op  = rw ? OP_START : OP_TXB;
        txb = cmd[7:0];
      end
      3'h4: begin
        op  = rw ? OP_TXB : OP_STOP;
        txb = adr_w | 8'h01;  // Direction bit set for read
      end
      3'h5: op = rw ? OP_RXB : OP_DONE;
      3'h6: op = rw ? OP_STOP : OP_DONE;
      3'h7: op = OP_DONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: ack one cycle after request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      cmd      <= 24'h0;
    end else begin
      wb_ack_o <= acc & ~wb_ack_o;
      if (acc & ~wb_ack_o)
        wb_dat_o <= rd_mux;
      // Command is frozen while a transfer runs
      if (wr & (wb_adr_i == WB_CMD) & ~busy) begin
        for (int i = 0; i < 3; i++) begin
          if (wb_sel_i[i])
            cmd[8*i +: 8] <= wb_dat_i[8*i +: 8];
        end
      end
    end
  end

  // Data line synchroniser
  always_ff @(posedge clk_i) begin
    sda_s1 <= link.sda;
    sda_s2 <= sda_s1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit engine: q0 set data, q1 raise clock, q2 sample, q3 lower clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy   <= 1'b0;
      nack   <= 1'b0;
      rx     <= 8'h00;
      step   <= 3'h0;
      q      <= 2'h0;
      bitn   <= 4'h0;
      div    <= 16'h0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (go) begin
      busy <= 1'b1;
      nack <= 1'b0;
      step <= 3'h0;
      q    <= 2'h0;
      bitn <= 4'h0;
      div  <= 16'h0;
    end else if (busy) begin
      div <= tick ? 16'h0 : div + 16'h1;
      if (tick) begin
        q <= q + 2'h1;
        unique case (op)
          // Start: data falls while clock high
          OP_START: begin
            if (q == 2'h0) begin
              scl_oe <= 1'b1;
              sda_oe <= 1'b0;
            end
            if (q == 2'h1)
              scl_oe <= 1'b0;
            if (q == 2'h2)
              sda_oe <= 1'b1;
            if (q == 2'h3) begin
              scl_oe <= 1'b1;
              step   <= step + 3'h1;
            end
          end
          // Bytes go out most significant bit first
          OP_TXB, OP_RXB: begin
            if (q == 2'h0)
              sda_oe <= (op == OP_TXB) & ~bitn[3] & ~txb[~bitn[2:0]];
            if (q == 2'h1)
              scl_oe <= 1'b0;
            if (q == 2'h2) begin
              if (op == OP_TXB && bitn[3])
                nack <= sda_s2;
              if (op == OP_RXB && !bitn[3])
                rx <= {rx[6:0], sda_s2};
            end
            if (q == 2'h3) begin
              scl_oe <= 1'b1;
              bitn   <= bitn[3] ? 4'h0 : bitn + 4'h1;
              // Refused byte ends the transfer early
              if (bitn[3])
                step <= (op == OP_TXB && nack) ? stop_step : step + 3'h1;
            end
          end
          // Every transfer ends with a stop
          OP_STOP: begin
            if (q == 2'h0)
              sda_oe <= 1'b1;
            if (q == 2'h1)
              scl_oe <= 1'b0;
            if (q == 2'h2)
              sda_oe <= 1'b0;
            if (q == 2'h3)
              step <= step + 3'h1;
          end
          OP_DONE: busy <= 1'b0;
        endcase
      end
    end
  end

  // Open-drain drive: only ever pulls low; one condition per high
  assign link.scl_host_oe = scl_oe;
  assign link.sda_host_oe = sda_oe;
  assign link.scl_host_o  = 1'b0;
  assign link.sda_host_o  = 1'b0;
endmodule
`default_nettype wire

//--- logic/agc_i2c_device.sv
// Device end: serial control slave, register file and gain path
`timescale 1ns/10ps
`default_nettype none
module agc_i2c_device (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  i2c_link_if.dev          link,
  input  wire logic        sample_clock_in_i,
  input  wire logic [9:0]  adc_data_i,
  input  wire logic        adc_chroma_i,
  input  wire logic        sync_in_i,
  input  wire logic        addr_select_pin_i,
  input  wire logic [63:0] aux_result_i,
  input  wire logic        aux_valid_i,
  output logic      [9:0]  video_o,
  output logic             chroma_phase_o
);
  import agc_i2c_pkg::*;

  typedef enum {S_IDLE, S_ADDR, S_SUB, S_WR, S_RD, S_ACK, S_MACK} slv_e;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two flops each, three for the sample clock
  logic [1:0]  ln_s1;         // Clock and data, first stage
  logic [1:0]  ln_s2;         // Second stage
  logic [1:0]  ln_f;          // Filtered levels
  logic [3:0]  fcnt [2];      // Stability counters
  logic [2:0]  smp_s;         // Sample clock, extra stage for edge
  logic [9:0]  adc_s1;
  logic [9:0]  adc_s2;
  logic [1:0]  misc_s1;       // Chroma flag, sync input
  logic [1:0]  misc_s2;
  logic        sel_s1;        // Address select pin
  logic        sel_s2;

  always_ff @(posedge clk_i) begin
    ln_s1   <= {link.scl, link.sda};
    ln_s2   <= ln_s1;
    smp_s   <= {smp_s[1:0], sample_clock_in_i};
    adc_s1  <= adc_data_i;
    adc_s2  <= adc_s1;
    misc_s1 <= {adc_chroma_i, sync_in_i};
    misc_s2 <= misc_s1;
    sel_s1  <= addr_select_pin_i;
    sel_s2  <= sel_s1;
  end

  // Glitch filter, select pin high: a change passes only after holding 50 ns;
  // costs that latency on every edge, harmless at link rates; pin low passes levels straight
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ln_f    <= 2'h3;
      fcnt[0] <= 4'h0;
      fcnt[1] <= 4'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!sel_s2 || ln_s2[i] == ln_f[i]) begin
          fcnt[i] <= 4'h0;
          if (!sel_s2)
            ln_f[i] <= ln_s2[i];  // Unfiltered path
        end else if (fcnt[i] == GLITCH_CNT) begin
          fcnt[i] <= 4'h0;
          ln_f[i] <= ln_s2[i];    // Held long enough
        end else begin
          fcnt[i] <= fcnt[i] + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line events
  logic       scl_d;
  logic       sda_d;
  logic [7:0] regs [REG_COUNT];   // Register file
  slv_e       state;
  slv_e       nxt;                // Phase after acknowledge
  logic [3:0] nbit;               // Bits shifted in this byte
  logic [7:0] sh;                 // Shift register
  logic [7:0] ptr;                // Subaddress pointer, write-only
  logic       oe;                 // Device pulls data low

  wire scl_f   = ln_f[1];
  wire sda_f   = ln_f[0];
  wire scl_rise = scl_f & ~scl_d;
  wire scl_fall = ~scl_f & scl_d;
  wire start_c = scl_f & scl_d & sda_d & ~sda_f;
  wire stop_c  = scl_f & scl_d & ~sda_d & sda_f;
  wire byte_done = scl_fall & (nbit == 4'h8);
  // Own address with bit one from the select pin
  wire addr_ok = sh[7:1] == {SLAVE_BASE[6:1], sel_s2};
  // Top bit set or past the last register is invalid
  wire sub_ok  = sh <= SUB_LAST;
  wire wr_ok   = ptr <= SUB_LAST;
  wire take    = (state == S_ADDR) ? addr_ok :
                 (state == S_SUB)  ? sub_ok : wr_ok;
  // Direction from the last address bit
  wire slv_e_rd = sh[0];
  wire [4:0] rd_idx = wr_ok ? ptr[4:0] : SUB_LAST[4:0];
  wire [7:0] rd_byte = regs[rd_idx];
  wire wr_en   = byte_done & (state == S_WR) & wr_ok;
  wire gain_wr = wr_en & (ptr == REG_GAIN_HI);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slave protocol engine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      nxt   <= S_IDLE;
      nbit  <= 4'h0;
      sh    <= 8'h00;
      ptr   <= 8'h00;
      oe    <= 1'b0;
    end else if (start_c) begin
      state <= S_ADDR;            // Restart from any position
      nbit  <= 4'h0;
      oe    <= 1'b0;
    end else if (stop_c) begin
      state <= S_IDLE;            // Stop from any position
      oe    <= 1'b0;
    end else begin
      unique case (state)
        S_IDLE: oe <= 1'b0;       // Watch for the next start
        // Address, subaddress and write data bytes
        S_ADDR, S_SUB, S_WR: begin
          if (scl_rise) begin
            sh   <= {sh[6:0], sda_f};
            nbit <= nbit + 4'h1;
          end else if (byte_done) begin
            nbit <= 4'h0;
            // Mismatch, bad subaddress or overrun: no ack
            oe    <= take;         // Ack on ninth clock
            state <= take ? S_ACK : S_IDLE;
            nxt   <= (state != S_ADDR) ? S_WR :
                     (slv_e_rd ? S_RD : S_SUB);
            if (take && state == S_SUB)
              ptr <= sh;
            if (take && state == S_WR)
              ptr <= ptr + 8'h01;  // Auto-increment
          end
        end
        // Release ack, or start driving a read byte
        S_ACK: begin
          if (scl_fall) begin
            nbit  <= 4'h0;
            state <= nxt;
            oe    <= 1'b0;
            if (nxt == S_RD) begin
              sh   <= rd_byte;
              oe   <= ~rd_byte[7];
              nbit <= 4'h1;
            end
          end
        end
        S_RD: begin
          if (scl_fall) begin
            if (nbit == 4'h8) begin
              oe    <= 1'b0;
              state <= S_MACK;
            end else begin
              oe   <= ~sh[6];
              sh   <= {sh[6:0], 1'b0};
              nbit <= nbit + 4'h1;
            end
          end
        end
        // Master ack continues a read, no-ack ends it
        S_MACK: begin
          if (scl_rise) begin
            state <= sda_f ? S_IDLE : S_ACK;
            nxt   <= S_RD;
            if (ptr < SUB_LAST)
              ptr <= ptr + 8'h01;  // Sticks at the last register
          end
        end
      endcase
    end
  end

  assign link.sda_dev_oe = oe;
  assign link.sda_dev_o  = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Register file: all read-write except the pointer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < REG_COUNT; i++)
        regs[i] <= (8'(i) == REG_GAIN_HI) ? GAIN_HI_RST : GAIN_LO_RST;
    end else begin
      // Auxiliary results land in their registers
      if (aux_valid_i) begin
        for (int i = 0; i < AUX_COUNT; i++)
          regs[REG_AUX0[4:0] + 5'(i)] <= aux_result_i[8*i +: 8];
      end
      // Serial write wins over a same-cycle auxiliary load
      if (wr_en)
        regs[ptr[4:0]] <= sh;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Gain and clamp staging
  logic [11:0] gain_new;    // Latched on high byte write
  logic        gain_pend;   // New gain waiting for blanking
  logic [11:0] gain_act;    // Gain in use, 3.9 fixed point
  logic [9:0]  clamp_act;   // Clamp level in use

  wire gate_en = regs[REG_CLAMP1[4:0]][SYNC_GATE_BIT];
  // Sync input high marks blanking; gating holds updates in video
  wire allow   = ~gate_en | misc_s2[0];
  wire smp_edge = smp_s[1] & ~smp_s[2];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_new  <= GAIN_RST;
      gain_pend <= 1'b0;
      gain_act  <= GAIN_RST;          // Gain of 2 after reset
      clamp_act <= 10'h000;
    end else begin
      if (gain_wr) begin
        // High byte completes the 12-bit gain
        gain_new <= {sh[3:0], regs[REG_GAIN_LO[4:0]]};
      end
      if (allow) begin
        // Updates only outside active video when gated
        clamp_act <= {regs[REG_CLAMP0[4:0]][6:0], 3'h0} << 1;
        if (gain_pend)
          gain_act <= gain_new;
      end
      // A new write in the transfer cycle stays pending
      gain_pend <= gain_wr | (gain_pend & ~allow);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Gain arithmetic around the clamp level
  logic signed [10:0] diff;
  logic signed [23:0] prod;
  logic        [15:0] sum;
  logic        [9:0]  sat;

  assign diff = $signed({1'b0, adc_s2}) - $signed({1'b0, clamp_act});
  assign prod = diff * $signed({1'b0, gain_act});
  assign sum  = {prod[23], prod[23:GAIN_FRAC]} + {6'h00, clamp_act};
  assign sat  = sum[15] ? 10'h000 :
                (|sum[14:10]) ? 10'h3ff : sum[9:0];

  // Output register, loaded on each sample clock rise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      video_o        <= 10'h000;
      chroma_phase_o <= 1'b0;
    end else if (smp_edge) begin
      video_o        <= sat;
      chroma_phase_o <= misc_s2[1];   // Cr or C word shown
    end
  end
endmodule
`default_nettype wire

//--- verif/agc_i2c_sva.sv
// Link checker watching the two-wire signals between both ends
`timescale 1ns/10ps
`default_nettype none
module agc_i2c_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_host_oe,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe
);
  import agc_i2c_pkg::*;
  logic       scl_q;  // Clock one cycle ago
  logic       sda_q;  // Data one cycle ago
  logic [4:0] cnt;    // Clock rises since start, 31 = idle
  logic [7:0] adr;    // Captured address byte
  logic [7:0] sub;    // Captured subaddress byte
  wire rise_w  = scl && !scl_q;
  wire start_w = scl && scl_q && sda_q && !sda;
  wire stop_w  = scl && scl_q && !sda_q && sda;

  ////////////////////////////////////////////////////////////////////////
  // Bit tracker, raw wires; both ends sample well after these edges
  always_ff @(posedge clk_i) begin
    scl_q <= scl;
    sda_q <= sda;
    if (rst_i || stop_w) begin
      cnt <= 5'h1f;
    end else if (start_w) begin
      cnt <= 5'h00;
    end else if (rise_w && cnt != 5'h1f) begin
      cnt <= cnt + 5'h01;
    end
    if (rise_w && cnt < 5'h08) adr <= {adr[6:0], sda};
    if (rise_w && cnt > 5'h08 && cnt < 5'h11) sub <= {sub[6:0], sda};
  end

  ////////////////////////////////////////////////////////////////////////
  // Conditions and properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence start_s; scl && $past(scl) && $fell(sda); endsequence
  sequence stop_s; scl && $past(scl) && $rose(sda); endsequence

  start_idle_a: assert property (start_s |-> !sda_dev_oe)
    else $error("device drives data at a start");
  stop_idle_a: assert property (stop_s |=> !sda_dev_oe [*8])
    else $error("device drives data after a stop");
  oe_hold_a: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
    else $error("device data moved while clock high");
  oe_move_a: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device data moved outside clock low");
  addr_quiet_a: assert property (rise_w && cnt < 5'h08 |-> !sda_dev_oe)
    else $error("device drives during address bits");
  sub_refuse_a: assert property (rise_w && cnt == 5'h11 && !adr[0]
    && sub > SUB_LAST |-> !sda_dev_oe)
    else $error("invalid subaddress acknowledged");
  read_free_a: assert property (rise_w && cnt == 5'h11 && adr[0]
    |-> !sda_dev_oe)
    else $error("device holds master acknowledge slot");
  host_free_a: assert property (rise_w && cnt == 5'h08
    |-> !sda_host_oe)
    else $error("controller drives the address acknowledge slot");
  rst_idle_a: assert property (disable iff (1'b0)
    $fell(rst_i) |-> !sda_dev_oe && sda)
    else $error("device drives data after reset");
  cover property (rise_w && cnt == 5'h08 && sda_dev_oe);
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Bench joining controller end and device end over the link
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); \
  n_mismatch++; end end
module testbench;
  import agc_i2c_pkg::*;
  logic        clk_i = 1'b0;   // 250 MHz core clock
  logic        rst_i = 1'b1;   // Sync reset
  logic        wb_cyc = 1'b0;  // Bus cycle
  logic        wb_stb = 1'b0;  // Bus strobe
  logic        wb_we = 1'b0;   // Bus direction
  logic [3:0]  wb_adr = 4'h0;  // Bus byte address
  logic [31:0] wb_wdat = '0;   // Bus write data
  logic [3:0]  wb_sel = 4'h0;  // Bus byte lanes
  logic [31:0] wb_rdat;        // Bus read data
  logic        wb_ack;         // Bus answer
  logic [2:0]  samp_div = '0;  // Sample clock divider, 32 ns period
  logic [9:0]  adc_data = '0;  // Converter word
  logic        adc_chroma = 0; // Chroma flag of word
  logic        sync_in = 1'b1; // Blanking level
  logic        addr_pin = 0;   // Address select pin
  logic [63:0] aux_res = '0;   // Aux bytes
  logic        aux_valid = 0;  // Aux load pulse
  logic [9:0]  video;          // Gain path output
  logic        chroma_phase;   // Chroma phase output
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          gain = 1024;    // Model gain, reset is two
  int          clamp = 0;      // Model clamp level
  logic [7:0]  rb;             // Byte read back
  logic        nk;             // Transfer refused
  logic [31:0] q;              // Bus word
  logic [7:0]  tbl [3] = '{8'h00, 8'h0c, 8'h17};

  i2c_link_if link ();
  i2c_master_end #(.QUARTER(16)) u_i2c_master_end (
    .clk_i(clk_i), .rst_i(rst_i), .link(link), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack));
  agc_i2c_device u_agc_i2c_device (
    .clk_i(clk_i), .rst_i(rst_i), .link(link),
    .sample_clock_in_i(samp_div[2]), .adc_data_i(adc_data),
    .adc_chroma_i(adc_chroma), .sync_in_i(sync_in),
    .addr_select_pin_i(addr_pin), .aux_result_i(aux_res),
    .aux_valid_i(aux_valid), .video_o(video),
    .chroma_phase_o(chroma_phase));
  agc_i2c_sva u_agc_i2c_sva (
    .clk_i(clk_i), .rst_i(rst_i), .scl(link.scl), .sda(link.sda),
    .scl_host_oe(link.scl_host_oe), .sda_host_oe(link.sda_host_oe),
    .sda_dev_oe(link.sda_dev_oe));

  always #2 clk_i = ~clk_i;
  // Sample clock from the core clock, so edges never race the bench
  always @(posedge clk_i) samp_div <= samp_div + 3'h1;

  ////////////////////////////////////////////////////////////////////////
  // One classic Wishbone cycle; held until ack is sampled high
  task automatic wb_xfer(input logic [3:0] a, input logic w,
                         input logic [31:0] d, output logic [31:0] r);
    int i;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    wb_sel <= 4'hf;
    for (i = 0; i < 50 && wb_ack !== 1'b1; i++) @(posedge clk_i);
    // A missing answer counts against the run
    `CHK("wb_ack", 1'b1, wb_ack)
    r = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_sel <= 4'h0;
    @(posedge clk_i);
  endtask

  // Launch a link transfer and poll status until idle
  task automatic link_op(input logic [7:0] s, d, input logic rd, a1,
                         output logic [7:0] b, output logic n);
    logic [31:0] r;
    int i;
    wb_xfer(WB_CMD, 1'b1, {14'h0, a1, rd, s, d}, r);
    r = 32'h1;
    for (i = 0; i < 2000 && r[0] !== 1'b0; i++)
      wb_xfer(WB_STAT, 1'b0, 32'h0, r);
    // A transfer that never ends counts against the run
    `CHK("link_idle", 1'b0, r[0])
    b = r[15:8];
    n = r[1];
  endtask

  // Gain equation with floor and saturation, from bench model values
  function automatic logic [9:0] agc(int a, int c, int g);
    int v;
    v = (((a - c) * g) >>> 9) + c;
    return (v < 0) ? 10'h000 : (v > 1023) ? 10'h3ff : 10'(v);
  endfunction

  // Hold a word for several samples, then compare the output
  task automatic vid(input logic [9:0] a, input string nm);
    adc_data <= a;
    repeat (40) @(posedge clk_i);
    `CHK(nm, agc(int'(a), clamp, gain), video)
  endtask

  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    repeat (95000) @(posedge clk_i);
    n_mismatch++;
    $display("watchdog expired");
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    link_op(REG_GAIN_HI, 8'h00, 1, 0, rb, nk);
    `CHK("gain_hi", GAIN_HI_RST, rb)
    link_op(REG_GAIN_LO, 8'h00, 1, 0, rb, nk);
    `CHK("gain_lo", GAIN_LO_RST, rb)
    vid(10'd100, "gain_two");
    $display("test reset done");
    link_op(REG_CLAMP0, 8'h10, 0, 0, rb, nk);
    `CHK("clamp_ack", 1'b0, nk)
    clamp = 256;
    vid(10'd300, "clamp");
    link_op(REG_GAIN_LO, 8'h4d, 0, 0, rb, nk);
    vid(10'd300, "lo_only");
    link_op(REG_GAIN_HI, 8'h07, 0, 0, rb, nk);
    gain = 'h74d;
    vid(10'd300, "gain_frac");
    vid(10'd1023, "sat_hi");
    vid(10'd0, "sat_lo");
    adc_chroma <= 1'b1;
    repeat (40) @(posedge clk_i);
    `CHK("chroma_hi", 1'b1, chroma_phase)
    adc_chroma <= 1'b0;
    repeat (40) @(posedge clk_i);
    `CHK("chroma_lo", 1'b0, chroma_phase)
    $display("test gain path done");
    sync_in <= 1'b0;
    link_op(REG_CLAMP1, 8'h01 << SYNC_GATE_BIT, 0, 0, rb, nk);
    link_op(REG_CLAMP0, 8'h00, 0, 0, rb, nk);
    vid(10'd200, "gated");
    sync_in <= 1'b1;
    clamp = 0;
    vid(10'd200, "blanking");
    $display("test sync gate done");
    foreach (tbl[k]) begin
      link_op(tbl[k], tbl[k] ^ 8'h5a, 0, 0, rb, nk);
      link_op(tbl[k], 8'h00, 1, 0, rb, nk);
      `CHK("reg_rw", tbl[k] ^ 8'h5a, rb)
    end
    aux_res <= 64'h8877665544332211;
    aux_valid <= 1'b1;
    @(posedge clk_i);
    aux_valid <= 1'b0;
    link_op(REG_AUX0, 8'h00, 1, 0, rb, nk);
    `CHK("aux_first", 8'h11, rb)
    link_op(SUB_LAST, 8'h00, 1, 0, rb, nk);
    `CHK("aux_last", 8'h88, rb)
    $display("test registers done");
    link_op(8'h18, 8'h33, 0, 0, rb, nk);
    `CHK("sub_over", 1'b1, nk)
    link_op(8'h84, 8'h33, 0, 0, rb, nk);
    `CHK("sub_top", 1'b1, nk)
    link_op(REG_GAIN_LO, 8'h00, 1, 0, rb, nk);
    `CHK("untouched", 8'h4d, rb)
    link_op(8'h01, 8'h3c, 0, 1, rb, nk);
    `CHK("a1_miss", 1'b1, nk)
    addr_pin <= 1'b1;
    repeat (20) @(posedge clk_i);
    link_op(8'h01, 8'h3c, 0, 1, rb, nk);
    `CHK("a1_hit", 1'b0, nk)
    link_op(8'h01, 8'h00, 1, 1, rb, nk);
    `CHK("a1_read", 8'h3c, rb)
    link_op(8'h01, 8'h00, 1, 0, rb, nk);
    `CHK("a1_old", 1'b1, nk)
    wb_xfer(4'h8, 1'b0, 32'h0, q);
    `CHK("unmapped", 32'h0, q)
    $display("test refusals done");
    end_sim();
  end
endmodule
`default_nettype wire
